// [cap_regs.svh]
// Functional notes
// - Each unit counts its recorded captures and zeroes that count when armed.
// - Each unit's position register holds the position sampled at its edge.
// - Stored captured positions follow a reference shift from homing or set-dimension.
// - Arm control writes decode as 0 abort, 1 single capture, 2 continuous capture.
// - Single mode disarms after its first capture; continuous stays armed until aborted.
// - Arming is accepted only while the drive is set for fieldbus control.
// - Edge select 0 captures on a falling edge, 1 on a rising edge, default 0.
// - Status word bit 0 shows that the first unit has captured.
// - Status word bit 1 shows that the second unit has captured.
// - Continuous mode overwrites the stored position at every qualifying edge.
// - There are two independent units, each with its own trigger input and settings.
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH

// Parameter addresses
`define CAP_STATUS_ADDR 16'h0a02
`define UNIT1_EDGE_ADDR 16'h0a04
`define UNIT2_EDGE_ADDR 16'h0a06
`define UNIT1_ARM_ADDR 16'h0a08
`define UNIT2_ARM_ADDR 16'h0a0a
`define UNIT1_POS_ADDR 16'h0a0c
`define UNIT2_POS_ADDR 16'h0a0e
`define UNIT1_TALLY_ADDR 16'h0a10
`define UNIT2_TALLY_ADDR 16'h0a12

// Arm control codes
`define ARM_CODE_ABORT 32'h0000_0000
`define ARM_CODE_ONCE 32'h0000_0001
`define ARM_CODE_CONT 32'h0000_0002

// Field values and resets
`define EDGE_RESET 1'b0
`define TALLY_RESET 16'h0000
`define TALLY_ONE 16'h0001
`define POS_RESET 32'h0000_0000
`define RD_RESET 32'h0000_0000

`endif

// [cap_pkg.sv]
package cap_pkg;

	typedef enum logic [1:0] {
		ARM_OFF = 2'b00,
		ARM_SINGLE = 2'b01,
		ARM_CONTINUOUS = 2'b10
	} arm_mode_t;

	// Per-unit state
	typedef struct packed {
		arm_mode_t mode;
		logic edge_rise;
		logic done;
		logic [15:0] tally;
		logic [31:0] pos;
	} unit_state_t;

	// Parameter access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} param_req_t;

	// Reference shift from homing or set-dimension
	typedef struct packed {
		logic update;
		logic [31:0] offset;
	} ref_shift_t;

endpackage

// [dual_position_capture.sv]
`timescale 1ns/10ps
`include "cap_regs.svh"

module dual_position_capture (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Parameter access
	input wire cap_pkg::param_req_t param_req,
	output logic [31:0] rd_data_q,
	output logic rd_valid_q,
	// Drive context
	input wire logic fieldbus_mode,
	input wire logic [31:0] position_in,
	input wire cap_pkg::ref_shift_t ref_shift,
	// Trigger inputs
	input wire logic first_trigger_input,
	input wire logic second_trigger_input
);

	localparam int NUM_UNITS = 2;
	localparam logic [15:0] EDGE_ADDR [NUM_UNITS] =
		'{`UNIT1_EDGE_ADDR, `UNIT2_EDGE_ADDR};
	localparam logic [15:0] ARM_ADDR [NUM_UNITS] =
		'{`UNIT1_ARM_ADDR, `UNIT2_ARM_ADDR};
	localparam logic [15:0] POS_ADDR [NUM_UNITS] =
		'{`UNIT1_POS_ADDR, `UNIT2_POS_ADDR};
	localparam logic [15:0] TALLY_ADDR [NUM_UNITS] =
		'{`UNIT1_TALLY_ADDR, `UNIT2_TALLY_ADDR};

	cap_pkg::unit_state_t unit_q [NUM_UNITS];
	logic [NUM_UNITS-1:0] trig_in;
	logic [NUM_UNITS-1:0] trig_meta_q;
	logic [NUM_UNITS-1:0] trig_sync_q;
	logic [NUM_UNITS-1:0] trig_prev_q;
	logic [NUM_UNITS-1:0] capture;
	logic [NUM_UNITS-1:0] arm_wr;
	logic [NUM_UNITS-1:0] arm_ok;
	logic [NUM_UNITS-1:0] abort;
	logic [31:0] rd_data_d;

	assign trig_in = {second_trigger_input, first_trigger_input};

	// Two-stage synchroniser, third stage keeps the previous level
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			trig_meta_q <= '0;
			trig_sync_q <= '0;
			trig_prev_q <= '0;
		end else begin
			trig_meta_q <= trig_in;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	// One independent unit per trigger input
	for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
		logic edge_seen;
		logic arm_code;
		cap_pkg::arm_mode_t new_mode;

		// Falling edge by default, rising when selected
		assign edge_seen = unit_q[i].edge_rise ?
			(trig_sync_q[i] & ~trig_prev_q[i]) :
			(~trig_sync_q[i] & trig_prev_q[i]);
		// Disarmed units ignore edges entirely
		assign capture[i] = edge_seen &&
			(unit_q[i].mode != cap_pkg::ARM_OFF);

		// Arm control decode
		assign arm_wr[i] = param_req.wr && (param_req.addr == ARM_ADDR[i]);
		assign arm_code = (param_req.wdata == `ARM_CODE_ONCE) ||
			(param_req.wdata == `ARM_CODE_CONT);
		// Only fieldbus control may arm; abort is always honoured
		assign arm_ok[i] = arm_wr[i] && arm_code && fieldbus_mode;
		assign abort[i] = arm_wr[i] &&
			(param_req.wdata == `ARM_CODE_ABORT);
		assign new_mode = (param_req.wdata == `ARM_CODE_CONT) ?
			cap_pkg::ARM_CONTINUOUS : cap_pkg::ARM_SINGLE;

		// Arm state; codes above 2 are ignored
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				unit_q[i].mode <= cap_pkg::ARM_OFF;
			end else if (arm_ok[i]) begin
				unit_q[i].mode <= new_mode;
			end else if (abort[i]) begin
				unit_q[i].mode <= cap_pkg::ARM_OFF;
			end else if (capture[i] &&
				unit_q[i].mode == cap_pkg::ARM_SINGLE) begin
				unit_q[i].mode <= cap_pkg::ARM_OFF;
			end
		end

		// Edge select register
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				unit_q[i].edge_rise <= `EDGE_RESET;
			end else if (param_req.wr &&
				param_req.addr == EDGE_ADDR[i]) begin
				unit_q[i].edge_rise <= param_req.wdata[0];
			end
		end

		// Done flag: a capture in the clearing cycle wins
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				unit_q[i].done <= 1'b0;
			end else begin
				unit_q[i].done <= capture[i] ||
					(unit_q[i].done && !(arm_ok[i] || abort[i]));
			end
		end

		// Event tally, zeroed on arming, same-cycle capture counted
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				unit_q[i].tally <= `TALLY_RESET;
			end else if (arm_ok[i]) begin
				unit_q[i].tally <= capture[i] ?
					`TALLY_ONE : `TALLY_RESET;
			end else if (capture[i]) begin
				unit_q[i].tally <= unit_q[i].tally + `TALLY_ONE;
			end
		end

		// Captured position; sampled three cycles after the pin edge
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				unit_q[i].pos <= `POS_RESET;
			end else if (capture[i]) begin
				unit_q[i].pos <= position_in;
			end else if (ref_shift.update) begin
				unit_q[i].pos <= unit_q[i].pos + ref_shift.offset;
			end
		end

		a_tally_arm_clear: assert property (@(posedge mclk)
			disable iff (!resetn)
			arm_ok[i] && !capture[i] |=> unit_q[i].tally == `TALLY_RESET)
			else $error("tally not cleared on arming");

		a_pos_sample: assert property (@(posedge mclk)
			disable iff (!resetn)
			capture[i] |=> unit_q[i].pos == $past(position_in))
			else $error("captured position mismatch");

		a_pos_recalc: assert property (@(posedge mclk)
			disable iff (!resetn)
			ref_shift.update && !capture[i] |=>
			unit_q[i].pos == $past(unit_q[i].pos) + $past(ref_shift.offset))
			else $error("position not recalculated");

		a_arm_decode: assert property (@(posedge mclk)
			disable iff (!resetn)
			arm_wr[i] && fieldbus_mode &&
			param_req.wdata == `ARM_CODE_CONT |=>
			unit_q[i].mode == cap_pkg::ARM_CONTINUOUS)
			else $error("continuous arm not decoded");

		a_single_disarm: assert property (@(posedge mclk)
			disable iff (!resetn)
			capture[i] && !arm_wr[i] &&
			unit_q[i].mode == cap_pkg::ARM_SINGLE |=>
			unit_q[i].mode == cap_pkg::ARM_OFF ##1
			(unit_q[i].mode == cap_pkg::ARM_OFF || $past(arm_ok[i])))
			else $error("single capture did not disarm");

		a_cont_holds: assert property (@(posedge mclk)
			disable iff (!resetn)
			unit_q[i].mode == cap_pkg::ARM_CONTINUOUS && !arm_wr[i] |=>
			unit_q[i].mode == cap_pkg::ARM_CONTINUOUS)
			else $error("continuous mode dropped");

		a_arm_needs_bus: assert property (@(posedge mclk)
			disable iff (!resetn)
			arm_wr[i] && !fieldbus_mode &&
			param_req.wdata != `ARM_CODE_ABORT |=>
			unit_q[i].mode == $past(unit_q[i].mode) ||
			unit_q[i].mode == cap_pkg::ARM_OFF)
			else $error("armed without fieldbus control");

		a_edge_counted: assert property (@(posedge mclk)
			disable iff (!resetn)
			$rose(trig_in[i]) ##2 (unit_q[i].edge_rise && !arm_wr[i] &&
			unit_q[i].mode != cap_pkg::ARM_OFF && $rose(trig_sync_q[i])) |=>
			unit_q[i].tally == $past(unit_q[i].tally) + `TALLY_ONE)
			else $error("selected edge not counted");

		a_idle_ignores: assert property (@(posedge mclk)
			disable iff (!resetn)
			unit_q[i].mode == cap_pkg::ARM_OFF && !arm_wr[i] &&
			!ref_shift.update |=> $stable(unit_q[i].pos) &&
			$stable(unit_q[i].tally) && $stable(unit_q[i].done))
			else $error("disarmed unit changed");

		a_done_on_capture: assert property (@(posedge mclk)
			disable iff (!resetn)
			capture[i] |=> unit_q[i].done)
			else $error("status not set on capture");
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_data_d = `RD_RESET;
		if (param_req.addr == `CAP_STATUS_ADDR) begin
			rd_data_d[1:0] = {unit_q[1].done, unit_q[0].done};
		end
		for (int k = 0; k < NUM_UNITS; k++) begin
			if (param_req.addr == EDGE_ADDR[k]) begin
				rd_data_d[0] = unit_q[k].edge_rise;
			end
			if (param_req.addr == ARM_ADDR[k]) begin
				rd_data_d[1:0] = unit_q[k].mode;
			end
			if (param_req.addr == POS_ADDR[k]) begin
				rd_data_d = unit_q[k].pos;
			end
			if (param_req.addr == TALLY_ADDR[k]) begin
				rd_data_d[15:0] = unit_q[k].tally;
			end
		end
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rd_data_q <= `RD_RESET;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= param_req.rd;
			if (param_req.rd) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	a_status_read: assert property (@(posedge mclk)
		disable iff (!resetn)
		param_req.rd && param_req.addr == `CAP_STATUS_ADDR |=>
		rd_valid_q && rd_data_q[1:0] ==
		{$past(unit_q[1].done), $past(unit_q[0].done)})
		else $error("status word read wrong");

endmodule

// [trig_src.sv]
`timescale 1ns/10ps

// Far-side trigger pins; levels change only on the clock edge
module trig_src (
	// Clock
	input wire logic mclk,
	// Requested pin levels
	input wire logic [1:0] want,
	// Trigger pins, low before the first edge
	output logic first_trigger_input = 1'b0,
	output logic second_trigger_input = 1'b0
);
	// Bench holds each level at least seven cycles, well over the two needed
	always @(posedge mclk) begin
		first_trigger_input <= want[0];
		second_trigger_input <= want[1];
	end
endmodule

// [dual_position_capture_tb.sv]
`timescale 1ns/10ps

module dual_position_capture_tb;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic fb = 1'b0;
	logic [31:0] pin = 32'h0;
	logic [1:0] want = 2'h0;
	logic t1, t2, rv;
	logic [31:0] rdat;
	cap_pkg::param_req_t req = '0;
	cap_pkg::ref_shift_t rs = '0;
	// Reference model of both units
	logic [31:0] m_pos [2];
	int m_tal [2], m_arm [2], m_sel [2], m_lv [2], m_st;
	int err_total = 0, comparisons = 0;

	trig_src ts (.mclk(mclk), .want(want), .first_trigger_input(t1),
		.second_trigger_input(t2));
	dual_position_capture DUT (.mclk(mclk), .resetn(resetn),
		.param_req(req), .rd_data_q(rdat), .rd_valid_q(rv),
		.fieldbus_mode(fb), .position_in(pin), .ref_shift(rs),
		.first_trigger_input(t1), .second_trigger_input(t2));

	// 250 MHz clock
	initial begin
		forever #2 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("mismatch rd_data_q exp %h seen %h", e, s);
		end
	endtask

	task automatic results;
		$display("errors %0d checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk) req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk) req <= '0;
	endtask

	// Read, wait a bounded time for the answer pulse, compare
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		int i;
		i = 0;
		@(posedge mclk) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge mclk) req <= '0;
		#1;
		while (rv !== 1'b1 && i < 4) begin
			@(posedge mclk);
			#1;
			i++;
		end
		if (i == 4) begin
			err_total++;
			results();
		end
		chk(rdat, e);
	endtask

	task automatic arm(input int u, input int c);
		wr(16'h0a08 + 16'(2 * u), 32'(c));
		if (c == 0 || (c <= 2 && fb)) begin
			m_arm[u] = c;
			m_st &= ~(1 << u);
			if (c != 0) m_tal[u] = 0;
		end
	endtask

	// Move one pin, fresh position, model the capture if it qualifies
	task automatic trig(input int u, input int lv);
		logic [31:0] p;
		p = $urandom;
		@(posedge mclk) begin
			pin <= p;
			want[u] <= 1'(lv);
		end
		repeat (6) @(posedge mclk);
		if (m_arm[u] != 0 && lv != m_lv[u] && lv == m_sel[u]) begin
			m_pos[u] = p;
			m_tal[u]++;
			m_st |= 1 << u;
			if (m_arm[u] == 1) m_arm[u] = 0;
		end
		m_lv[u] = lv;
	endtask

	task automatic chk_all;
		for (int u = 0; u < 2; u++) begin
			rd(16'h0a0c + 16'(2 * u), m_pos[u]);
			rd(16'h0a10 + 16'(2 * u), 32'(m_tal[u]));
			rd(16'h0a08 + 16'(2 * u), 32'(m_arm[u]));
		end
		rd(16'h0a02, 32'(m_st));
	endtask

	initial begin
		logic [31:0] off;
		void'($urandom(32'h5fe0));
		m_pos = '{32'h0, 32'h0};
		m_tal = '{0, 0};
		m_arm = '{0, 0};
		m_sel = '{0, 0};
		m_lv = '{0, 0};
		m_st = 0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		rd(16'h0a04, 32'h0);
		rd(16'h0a06, 32'h0);
		rd(16'h0a20, 32'h0);
		chk_all();
		// Single capture on rising edge; later edges ignored
		@(posedge mclk) fb <= 1'b1;
		wr(16'h0a04, 32'h1);
		m_sel[0] = 1;
		rd(16'h0a04, 32'h1);
		arm(0, 1);
		trig(0, 1);
		trig(0, 0);
		trig(0, 1);
		chk_all();
		// Continuous on falling edges, each overwrites the last
		arm(1, 2);
		for (int k = 0; k < 4; k++) trig(1, (k + 1) % 2);
		chk_all();
		// Reference shift moves every stored position
		off = $urandom;
		@(posedge mclk) rs <= '{1'b1, off};
		@(posedge mclk) rs <= '0;
		for (int u = 0; u < 2; u++) m_pos[u] += off;
		chk_all();
		// Abort clears status; disarmed edges do nothing
		arm(1, 0);
		trig(1, 1);
		trig(1, 0);
		chk_all();
		// Arming refused outside fieldbus control, bad code ignored
		@(posedge mclk) fb <= 1'b0;
		arm(0, 1);
		arm(0, 3);
		trig(0, 0);
		trig(0, 1);
		chk_all();
		// Re-arm clears the tally
		@(posedge mclk) fb <= 1'b1;
		arm(0, 2);
		chk_all();
		// Continuous on rising edges, single on falling edges
		arm(1, 1);
		trig(0, 0);
		trig(0, 1);
		trig(1, 1);
		trig(1, 0);
		trig(1, 1);
		trig(1, 0);
		chk_all();
		results();
	end
endmodule
